// File: common/rwg_pkg.sv
// constants and types for the core register resources and guard
// Function
// - 32 byte registers, own address space
// - four read/write-back width patterns
// - r26..r31 form three low/high pointers
// - third pointer addresses flash, fuses, signatures
// - pointers: displacement, post-increment, pre-decrement
// - each pointer has own extension byte
// - extension bytes optional, only needed bits
// - extended flash ops use extension; plain load not
// - direct extension byte prefixes direct operand
// - jump extension prefixes third pointer
// - low write held, committed with high
// - low read latches high into temp
// - temp bytes directly readable and writable
// - 16/32-bit use one/three temp bytes
// - guard blocks protected writes and flash ops
// - signature opens four-instruction window, two modes
// - io mode closes on writes, flash, sleep
// - flash mode closes on data write, sleep
// - interrupt servicing suppressed while window open
// - dma ignored for signature and window
// - 0xd8 io mode, 0x9d flash mode
// - guard reads mode bits, rest zero
package rwg_pkg;

   localparam int NUM_REGS = 32;
   localparam int BYTE_W   = 8;
   localparam int RADDR_W  = 5;
   localparam int BUS_AW   = 4;

   // first pointer low byte; pairs follow upward
   localparam logic [4:0] PTR_BASE = 5'h1a;
   localparam int         NUM_PTRS = 3;

   // bus word offsets
   localparam logic [3:0] OFF_GUARD   = 4'h0;
   localparam logic [3:0] OFF_EXT_P0  = 4'h1;
   localparam logic [3:0] OFF_EXT_P1  = 4'h2;
   localparam logic [3:0] OFF_EXT_P2  = 4'h3;
   localparam logic [3:0] OFF_EXT_DIR = 4'h4;
   localparam logic [3:0] OFF_EXT_JMP = 4'h5;
   localparam logic [3:0] OFF_TEMP0   = 4'h6;
   localparam logic [3:0] OFF_TEMP1   = 4'h7;
   localparam logic [3:0] OFF_TEMP2   = 4'h8;
   localparam logic [3:0] OFF_TICK_LO = 4'h9;
   localparam logic [3:0] OFF_TICK_HI = 4'ha;
   localparam logic [3:0] OFF_WIDE_B0 = 4'hb;
   localparam logic [3:0] OFF_WIDE_B1 = 4'hc;
   localparam logic [3:0] OFF_WIDE_B2 = 4'hd;
   localparam logic [3:0] OFF_WIDE_B3 = 4'he;

   localparam logic [7:0] SIG_IO    = 8'hd8;
   localparam logic [7:0] SIG_FLASH = 8'h9d;
   localparam int GUARD_IO_BIT    = 0;
   localparam int GUARD_FLASH_BIT = 1;
   localparam logic [2:0] WINDOW_INSTR = 3'h4;

   typedef enum logic [1:0] {
      RWG_PTR_DISP    = 2'h0,
      RWG_PTR_POSTINC = 2'h1,
      RWG_PTR_PREDEC  = 2'h2
   } rwg_ptr_mode_t;

   typedef enum logic [1:0] {
      RWG_FL_NONE     = 2'h0,
      RWG_FL_LOAD     = 2'h1,
      RWG_FL_EXT_LOAD = 2'h2,
      RWG_FL_STORE    = 2'h3
   } rwg_flash_op_t;

   // gray: closed->io and closed->flash are one-bit steps
   typedef enum logic [1:0] {
      RWG_GUARD_CLOSED = 2'h0,
      RWG_GUARD_IO     = 2'h1,
      RWG_GUARD_FLASH  = 2'h2
   } rwg_guard_state_t;

endpackage

// File: rtl/rwg_regfile_mem.sv
// working register storage with registered dual read and two write ports
`timescale 1ns/1ps
`default_nettype none
module rwg_regfile_mem #(
   parameter int DEPTH = 32,
   parameter int W     = 8,
   parameter int AW    = 5,
   parameter int NPTR  = 3
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // read ports
   input  wire logic [AW-1:0]     rdAddrA,
   input  wire logic [AW-1:0]     rdAddrB,
   input  wire logic              rdWide,
   output logic      [W-1:0]      rdDataA,
   output logic      [W-1:0]      rdDataB,
   // result write port
   input  wire logic              wrEn,
   input  wire logic              wrWide,
   input  wire logic [AW-1:0]     wrAddr,
   input  wire logic [2*W-1:0]    wrData,
   // pointer update write port
   input  wire logic              ptrWrEn,
   input  wire logic [AW-1:0]     ptrWrAddr,
   input  wire logic [2*W-1:0]    ptrWrData,
   // pointer bytes, low pair first
   output logic      [2*NPTR*W-1:0] ptrBytes
);
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] pairLo;
   logic [AW-1:0] pairHi;

   assign pairLo = {rdAddrA[AW-1:1], 1'b0};
   assign pairHi = {rdAddrA[AW-1:1], 1'b1};

   // reads return the value before a same-cycle write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdDataA <= '0;
         rdDataB <= '0;
      end else if (rdWide) begin
         rdDataA <= mem_ff[pairLo];
         rdDataB <= mem_ff[pairHi];
      end else begin
         rdDataA <= mem_ff[rdAddrA];
         rdDataB <= mem_ff[rdAddrB];
      end
   end

   // pointer update is applied last and wins a collision
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else begin
         if (wrEn && wrWide) begin
            mem_ff[{wrAddr[AW-1:1], 1'b0}] <= wrData[W-1:0];
            mem_ff[{wrAddr[AW-1:1], 1'b1}] <= wrData[2*W-1:W];
         end else if (wrEn) begin
            mem_ff[wrAddr] <= wrData[W-1:0];
         end
         if (ptrWrEn) begin
            mem_ff[ptrWrAddr]                      <= ptrWrData[W-1:0];
            mem_ff[AW'(ptrWrAddr + AW'(1))]         <= ptrWrData[2*W-1:W];
         end
      end
   end

   generate
      for (genvar g = 0; g < 2*NPTR; g++) begin : gPtr
         assign ptrBytes[g*W +: W] = mem_ff[DEPTH-2*NPTR+g];
      end
   endgenerate

endmodule
`default_nettype wire

// File: rtl/rwg_core_regs.sv
// core register resources: working registers, pointer extensions,
// atomic wide access and the configuration change guard
`timescale 1ns/1ps
`default_nettype none
module rwg_core_regs #(
   parameter bit HAS_EXT  = 1'b1,
   parameter int EXT_BITS = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // avalon-mm slave
   input  wire logic [3:0]   address,
   input  wire logic         read,
   input  wire logic         write,
   input  wire logic [31:0]  writedata,
   input  wire logic [3:0]   byteenable,
   output logic      [31:0]  readdata,
   output logic              waitrequest,
   input  wire logic         busFromDma,
   // working register access
   input  wire logic [4:0]   rdAddrA,
   input  wire logic [4:0]   rdAddrB,
   input  wire logic         rdWide,
   output logic      [7:0]   rdDataA,
   output logic      [7:0]   rdDataB,
   input  wire logic         wrEn,
   input  wire logic         wrWide,
   input  wire logic [4:0]   wrAddr,
   input  wire logic [15:0]  wrData,
   // pointer addressing
   input  wire logic         ptrReq,
   input  wire logic [1:0]   ptrSel,
   input  wire rwg_pkg::rwg_ptr_mode_t ptrMode,
   input  wire logic [5:0]   ptrDisp,
   output logic      [23:0]  ptrAddr,
   output logic              ptrAddrValid,
   // direct addressing and indirect jump
   input  wire logic [15:0]  dirOperand,
   output logic      [23:0]  dirAddr,
   output logic      [23:0]  jumpTarget,
   // flash access
   input  wire logic         flashReq,
   input  wire rwg_pkg::rwg_flash_op_t flashOp,
   input  wire logic         flashIsFuseSig,
   output logic      [23:0]  flashAddr,
   output logic              flashBlocked,
   // guard events and controls
   input  wire logic         instrDone,
   input  wire logic         sleepExec,
   input  wire logic         dataMemWr,
   output logic              ioChangeEn,
   output logic              intSuppress
);
   localparam logic [7:0] EXT_MASK = HAS_EXT ? 8'((1 << EXT_BITS) - 1) : 8'h00;
   localparam int PW = 2 * rwg_pkg::BYTE_W;

   // ------------------------------
   // bus handshake
   // ------------------------------
   logic ack_ff;
   logic actWr;
   logic capRd;
   logic cpuWr;
   logic [7:0] wd;

   assign waitrequest = (read | write) & ~ack_ff;
   assign actWr       = write & ack_ff & byteenable[0];
   assign capRd       = read & ~ack_ff;
   assign cpuWr       = actWr & ~busFromDma;
   assign wd          = writedata[7:0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (read | write) & ~ack_ff;
      end
   end

   // ------------------------------
   // working registers
   // ------------------------------
   logic [3*PW-1:0] ptrBytes;
   logic [PW-1:0]   ptrCur;
   logic [PW-1:0]   ptrNew;
   logic [PW-1:0]   ptrEff;
   logic [4:0]      ptrPair;
   logic [1:0]      ptrIdx;

   // unused selector code falls back to the first pointer
   assign ptrIdx  = (ptrSel == 2'h3) ? 2'h0 : ptrSel;
   assign ptrCur  = ptrBytes[ptrIdx*PW +: PW];
   assign ptrPair = 5'(rwg_pkg::PTR_BASE + 5'({ptrIdx, 1'b0}));

   always_comb begin
      ptrNew = ptrCur;
      ptrEff = ptrCur;
      unique case (ptrMode)
         rwg_pkg::RWG_PTR_POSTINC: begin
            ptrNew = PW'(ptrCur + PW'(1));
         end
         rwg_pkg::RWG_PTR_PREDEC: begin
            ptrNew = PW'(ptrCur - PW'(1));
            ptrEff = ptrNew;
         end
         rwg_pkg::RWG_PTR_DISP: begin
            ptrEff = PW'(ptrCur + PW'(ptrDisp));
         end
         default: begin
            ptrEff = ptrCur;
         end
      endcase
   end

   rwg_regfile_mem #(
      .DEPTH (rwg_pkg::NUM_REGS),
      .W     (rwg_pkg::BYTE_W),
      .AW    (rwg_pkg::RADDR_W),
      .NPTR  (rwg_pkg::NUM_PTRS)
   ) uMem (
      .clk       (clk),
      .rst_n     (rst_n),
      .rdAddrA   (rdAddrA),
      .rdAddrB   (rdAddrB),
      .rdWide    (rdWide),
      .rdDataA   (rdDataA),
      .rdDataB   (rdDataB),
      .wrEn      (wrEn),
      .wrWide    (wrWide),
      .wrAddr    (wrAddr),
      .wrData    (wrData),
      .ptrWrEn   (ptrReq && ptrMode != rwg_pkg::RWG_PTR_DISP),
      .ptrWrAddr (ptrPair),
      .ptrWrData (ptrNew),
      .ptrBytes  (ptrBytes)
   );

   // ------------------------------
   // extension bytes
   // ------------------------------
   logic [7:0] extPtr_ff [rwg_pkg::NUM_PTRS];
   logic [7:0] extDir_ff;
   logic [7:0] extJmp_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < rwg_pkg::NUM_PTRS; i++) begin
            extPtr_ff[i] <= 8'h00;
         end
         extDir_ff <= 8'h00;
         extJmp_ff <= 8'h00;
      end else if (actWr) begin
         unique case (address)
            rwg_pkg::OFF_EXT_P0:  extPtr_ff[0] <= wd & EXT_MASK;
            rwg_pkg::OFF_EXT_P1:  extPtr_ff[1] <= wd & EXT_MASK;
            rwg_pkg::OFF_EXT_P2:  extPtr_ff[2] <= wd & EXT_MASK;
            rwg_pkg::OFF_EXT_DIR: extDir_ff    <= wd & EXT_MASK;
            rwg_pkg::OFF_EXT_JMP: extJmp_ff    <= wd & EXT_MASK;
            default: ;
         endcase
      end
   end

   // ------------------------------
   // address formation
   // ------------------------------
   logic [PW-1:0] zPtr;

   assign zPtr = ptrBytes[2*PW +: PW];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptrAddr      <= 24'h000000;
         ptrAddrValid <= 1'b0;
         dirAddr      <= 24'h000000;
         jumpTarget   <= 24'h000000;
         flashAddr    <= 24'h000000;
      end else begin
         ptrAddr      <= {extPtr_ff[ptrIdx], ptrEff};
         ptrAddrValid <= ptrReq;
         dirAddr      <= {extDir_ff, dirOperand};
         jumpTarget   <= {extJmp_ff, zPtr};
         if (flashOp == rwg_pkg::RWG_FL_LOAD) begin
            flashAddr <= {8'h00, zPtr};
         end else begin
            flashAddr <= {extPtr_ff[2], zPtr};
         end
      end
   end

   // ------------------------------
   // atomic wide access
   // ------------------------------
   logic [7:0]  temp_ff [3];
   logic [15:0] tick_ff;
   logic [31:0] wide_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 3; i++) begin
            temp_ff[i] <= 8'h00;
         end
      end else if (capRd && address == rwg_pkg::OFF_TICK_LO) begin
         temp_ff[0] <= tick_ff[15:8];
      end else if (capRd && address == rwg_pkg::OFF_WIDE_B0) begin
         temp_ff[0] <= wide_ff[15:8];
         temp_ff[1] <= wide_ff[23:16];
         temp_ff[2] <= wide_ff[31:24];
      end else if (actWr) begin
         unique case (address)
            rwg_pkg::OFF_TEMP0,
            rwg_pkg::OFF_TICK_LO,
            rwg_pkg::OFF_WIDE_B0: temp_ff[0] <= wd;
            rwg_pkg::OFF_TEMP1,
            rwg_pkg::OFF_WIDE_B1: temp_ff[1] <= wd;
            rwg_pkg::OFF_TEMP2,
            rwg_pkg::OFF_WIDE_B2: temp_ff[2] <= wd;
            default: ;
         endcase
      end
   end

   // free-running 16-bit counter, loadable atomically
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_ff <= 16'h0000;
      end else if (actWr && address == rwg_pkg::OFF_TICK_HI) begin
         tick_ff <= {wd, temp_ff[0]};
      end else begin
         tick_ff <= 16'(tick_ff + 16'h0001);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wide_ff <= 32'h00000000;
      end else if (actWr && address == rwg_pkg::OFF_WIDE_B3) begin
         wide_ff <= {wd, temp_ff[2], temp_ff[1], temp_ff[0]};
      end
   end

   // ------------------------------
   // configuration change guard
   // ------------------------------
   rwg_pkg::rwg_guard_state_t guard_ff;
   logic [2:0] winCnt_ff;
   logic sigWr;
   logic winDone;
   logic closeIo;
   logic closeFl;

   // dma writes neither open nor close the window
   assign sigWr   = cpuWr && address == rwg_pkg::OFF_GUARD;
   assign winDone = instrDone && winCnt_ff == 3'(rwg_pkg::WINDOW_INSTR - 3'h1);
   assign closeIo = cpuWr | dataMemWr | flashReq | sleepExec | winDone;
   assign closeFl = cpuWr | dataMemWr | sleepExec | winDone;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         guard_ff <= rwg_pkg::RWG_GUARD_CLOSED;
      end else if (sigWr && wd == rwg_pkg::SIG_IO) begin
         guard_ff <= rwg_pkg::RWG_GUARD_IO;
      end else if (sigWr && wd == rwg_pkg::SIG_FLASH) begin
         guard_ff <= rwg_pkg::RWG_GUARD_FLASH;
      end else begin
         unique case (guard_ff)
            rwg_pkg::RWG_GUARD_CLOSED: guard_ff <= rwg_pkg::RWG_GUARD_CLOSED;
            rwg_pkg::RWG_GUARD_IO: begin
               if (closeIo) begin
                  guard_ff <= rwg_pkg::RWG_GUARD_CLOSED;
               end
            end
            rwg_pkg::RWG_GUARD_FLASH: begin
               if (closeFl) begin
                  guard_ff <= rwg_pkg::RWG_GUARD_CLOSED;
               end
            end
            default: guard_ff <= rwg_pkg::RWG_GUARD_CLOSED;
         endcase
      end
   end

   // counts completed instructions inside the window
   always_ff @(posedge clk) begin
      if (!rst_n || sigWr) begin
         winCnt_ff <= 3'h0;
      end else if (guard_ff != rwg_pkg::RWG_GUARD_CLOSED && instrDone) begin
         winCnt_ff <= 3'(winCnt_ff + 3'h1);
      end
   end

   assign ioChangeEn  = guard_ff == rwg_pkg::RWG_GUARD_IO;
   assign intSuppress = guard_ff != rwg_pkg::RWG_GUARD_CLOSED;
   assign flashBlocked = guard_ff != rwg_pkg::RWG_GUARD_FLASH
      && (flashOp == rwg_pkg::RWG_FL_STORE
          || (flashOp != rwg_pkg::RWG_FL_NONE && flashIsFuseSig));

   // ------------------------------
   // read data
   // ------------------------------
   logic [7:0] rdByte;

   always_comb begin
      rdByte = 8'h00;
      unique case (address)
         rwg_pkg::OFF_GUARD: begin
            rdByte[rwg_pkg::GUARD_IO_BIT]    = guard_ff == rwg_pkg::RWG_GUARD_IO;
            rdByte[rwg_pkg::GUARD_FLASH_BIT] = guard_ff == rwg_pkg::RWG_GUARD_FLASH;
         end
         rwg_pkg::OFF_EXT_P0:  rdByte = extPtr_ff[0];
         rwg_pkg::OFF_EXT_P1:  rdByte = extPtr_ff[1];
         rwg_pkg::OFF_EXT_P2:  rdByte = extPtr_ff[2];
         rwg_pkg::OFF_EXT_DIR: rdByte = extDir_ff;
         rwg_pkg::OFF_EXT_JMP: rdByte = extJmp_ff;
         rwg_pkg::OFF_TEMP0,
         rwg_pkg::OFF_TICK_HI,
         rwg_pkg::OFF_WIDE_B1: rdByte = temp_ff[0];
         rwg_pkg::OFF_TEMP1,
         rwg_pkg::OFF_WIDE_B2: rdByte = temp_ff[1];
         rwg_pkg::OFF_TEMP2,
         rwg_pkg::OFF_WIDE_B3: rdByte = temp_ff[2];
         rwg_pkg::OFF_TICK_LO: rdByte = tick_ff[7:0];
         rwg_pkg::OFF_WIDE_B0: rdByte = wide_ff[7:0];
         default:              rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readdata <= 32'h00000000;
      end else if (capRd) begin
         readdata <= {24'h000000, rdByte};
      end
   end

endmodule
`default_nettype wire

// File: verif/rwg_core_regs_sva.sv
// assertions on the core register resources ports
`timescale 1ns/1ps
`default_nettype none
module rwg_core_regs_sva (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   rst_n,
   // bus
   input wire logic [3:0]             address,
   input wire logic                   read,
   input wire logic                   write,
   input wire logic [31:0]            writedata,
   input wire logic [3:0]             byteenable,
   input wire logic [31:0]            readdata,
   input wire logic                   waitrequest,
   input wire logic                   busFromDma,
   // register file
   input wire logic [4:0]             rdAddrA,
   input wire logic [7:0]             rdDataA,
   input wire logic                   wrEn,
   input wire logic                   wrWide,
   input wire logic [4:0]             wrAddr,
   input wire logic [15:0]            wrData,
   input wire logic                   ptrReq,
   // flash and guard
   input wire logic                   flashReq,
   input wire rwg_pkg::rwg_flash_op_t flashOp,
   input wire logic [23:0]            flashAddr,
   input wire logic                   flashBlocked,
   input wire logic                   instrDone,
   input wire logic                   sleepExec,
   input wire logic                   dataMemWr,
   input wire logic                   ioChangeEn,
   input wire logic                   intSuppress
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // --------------------
   // helpers
   // --------------------
   logic       sigAck;
   logic       cpuWr;
   logic [7:0] wrLow;
   logic [2:0] instrCnt_ff;
   assign cpuWr  = write && !waitrequest && byteenable[0] && !busFromDma;
   assign sigAck = cpuWr && address == 4'h0;
   assign wrLow  = wrData[7:0];
   // instructions retired while the window is open since the last guard write
   always_ff @(posedge clk) begin
      if (!rst_n || sigAck) begin
         instrCnt_ff <= 3'h0;
      end else if (instrDone && intSuppress) begin
         instrCnt_ff <= instrCnt_ff + 3'h1;
      end
   end
   // --------------------
   // assertions
   // --------------------
   chk_io_open: assert property (
      sigAck && writedata[7:0] == 8'hd8 |=> ioChangeEn && intSuppress)
      else $error("io window not open");
   chk_flash_open: assert property (
      sigAck && writedata[7:0] == 8'h9d |=> !ioChangeEn && intSuppress)
      else $error("flash window not open");
   chk_window_len: assert property (
      intSuppress |-> instrCnt_ff < 3'h4)
      else $error("window too long");
   chk_io_close: assert property (
      ioChangeEn && !sigAck && (flashReq || dataMemWr || sleepExec || cpuWr)
      |=> !intSuppress)
      else $error("io window stays open");
   chk_flash_close: assert property (
      intSuppress && !ioChangeEn && !sigAck && (dataMemWr || sleepExec) |=> !intSuppress)
      else $error("flash window stays open");
   chk_store_block: assert property (
      flashOp == rwg_pkg::RWG_FL_STORE && (ioChangeEn || !intSuppress) |-> flashBlocked)
      else $error("store not blocked");
   chk_guard_read: assert property (
      read && !waitrequest && address == 4'h0 |-> readdata[31:2] == 30'h0 &&
      readdata[1:0] == {$past(intSuppress) && !$past(ioChangeEn), $past(ioChangeEn)})
      else $error("guard read wrong");
   chk_rf_write: assert property (
      wrEn && !wrWide && !ptrReq && rdAddrA == wrAddr ##1 !wrEn && !ptrReq && $stable(rdAddrA)
      |=> rdDataA == $past(wrLow, 2))
      else $error("register byte lost");
   chk_load_noext: assert property (
      flashReq && flashOp == rwg_pkg::RWG_FL_LOAD |=> flashAddr[23:16] == 8'h00)
      else $error("load used extension");
   cov_io: cover property (sigAck && writedata[7:0] == 8'hd8);
   cov_flash: cover property (sigAck && writedata[7:0] == 8'h9d);
   cov_close: cover property (intSuppress ##1 !intSuppress);
endmodule
bind rwg_core_regs rwg_core_regs_sva u_chk (.clk, .rst_n, .address, .read, .write,
   .writedata, .byteenable, .readdata, .waitrequest, .busFromDma, .rdAddrA, .rdDataA,
   .wrEn, .wrWide, .wrAddr, .wrData, .ptrReq, .flashReq, .flashOp, .flashAddr,
   .flashBlocked, .instrDone, .sleepExec, .dataMemWr, .ioChangeEn, .intSuppress);
`default_nettype wire

// File: verif/rwg_cpu_model.sv
// pipeline model: retires instructions and raises guard events
`timescale 1ns/1ps
`default_nettype none
module rwg_cpu_model (
   // clock
   input  wire logic                  clk,
   // pipeline events
   output var logic                   instrDone,
   output var logic                   sleepExec,
   output var logic                   dataMemWr,
   output var logic                   flashReq,
   output var rwg_pkg::rwg_flash_op_t flashOp,
   output var logic                   flashIsFuseSig
);
   initial begin
      {instrDone, sleepExec, dataMemWr, flashReq, flashIsFuseSig} = 5'h00;
      flashOp = rwg_pkg::RWG_FL_NONE;
   end
   // one event pulse per call; no interrupt handler is modelled, so nothing
   // slips between the bytes of a wide access
   task automatic step(input logic [1:0] kind, input rwg_pkg::rwg_flash_op_t op,
                       input logic fz);
      @(posedge clk);
      instrDone <= kind == 2'h0;
      sleepExec <= kind == 2'h1;
      dataMemWr <= kind == 2'h2;
      flashReq <= kind == 2'h3;
      flashOp <= op;
      flashIsFuseSig <= fz;
      @(posedge clk);
      {instrDone, sleepExec, dataMemWr, flashReq} <= 4'h0;
   endtask
endmodule
`default_nettype wire

// File: verif/tb_rwg_core_regs.sv
// self-checking bench for the core register resources
`timescale 1ns/1ps
`default_nettype none
module tb_rwg_core_regs;
   logic                   clk, rst_n, read, write, waitrequest, busFromDma, rdWide;
   logic                   wrEn, wrWide, ptrReq, ptrAddrValid, flashReq, flashIsFuseSig;
   logic                   flashBlocked, instrDone, sleepExec, dataMemWr;
   logic                   ioChangeEn, intSuppress;
   logic [1:0]             ptrSel;
   logic [3:0]             address, byteenable;
   logic [4:0]             rdAddrA, rdAddrB, wrAddr;
   logic [5:0]             ptrDisp;
   logic [7:0]             rdDataA, rdDataB;
   logic [15:0]            wrData, dirOperand;
   logic [23:0]            ptrAddr, dirAddr, jumpTarget, flashAddr, rdq;
   logic [31:0]            writedata, readdata;
   rwg_pkg::rwg_ptr_mode_t ptrMode;
   rwg_pkg::rwg_flash_op_t flashOp;
   int                     n_fail, num_checks, cycles;
   logic [7:0]             sg [5] = '{8'h9d, 8'h9d, 8'hd8, 8'hd8, 8'h55};
   logic [7:0]             gv [5] = '{8'h02, 8'h02, 8'h01, 8'h00, 8'h00};
   logic [1:0]             ev [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1};

   rwg_core_regs uut (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .busFromDma, .rdAddrA, .rdAddrB, .rdWide, .rdDataA,
      .rdDataB, .wrEn, .wrWide, .wrAddr, .wrData, .ptrReq, .ptrSel, .ptrMode, .ptrDisp,
      .ptrAddr, .ptrAddrValid, .dirOperand, .dirAddr, .jumpTarget, .flashReq, .flashOp,
      .flashIsFuseSig, .flashAddr, .flashBlocked, .instrDone, .sleepExec, .dataMemWr,
      .ioChangeEn, .intSuppress);
   rwg_cpu_model cpu (.clk, .instrDone, .sleepExec, .dataMemWr, .flashReq, .flashOp,
      .flashIsFuseSig);
   // --------------------
   // tasks
   // --------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // avalon request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      write <= w;
      read <= !w;
      address <= a;
      writedata <= {24'h0, d};
      do @(posedge clk); while (waitrequest !== 1'b0);
      rdq = readdata[23:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk("readdata", {16'h0, e}, rdq);
   endtask
   task automatic ptr(input logic [1:0] s, input rwg_pkg::rwg_ptr_mode_t m,
                      input logic [5:0] d, input logic [23:0] e);
      @(posedge clk);
      ptrReq <= 1'b1;
      ptrSel <= s;
      ptrMode <= m;
      ptrDisp <= d;
      @(posedge clk);
      ptrReq <= 1'b0;
      @(negedge clk);
      chk("ptrAddr", e, ptrAddr);
      chk("ptrAddrValid", 24'h1, {23'h0, ptrAddrValid});
   endtask
   task automatic rf(input logic [4:0] a, input logic w, input logic [15:0] e);
      @(posedge clk);
      rdAddrA <= a;
      rdAddrB <= a;
      rdWide <= w;
      @(posedge clk);
      @(negedge clk);
      chk("rdData", {8'h0, e}, {8'h0, rdDataB, rdDataA});
   endtask
   // --------------------
   // clock, watchdog and sequence
   // --------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      {rst_n, read, write, busFromDma, rdWide, wrEn, wrWide, ptrReq} = 8'h00;
      {address, writedata, rdAddrA, rdAddrB, wrAddr, wrData, ptrSel, ptrDisp} = '0;
      byteenable = 4'h1;
      dirOperand = 16'h0;
      ptrMode = rwg_pkg::RWG_PTR_DISP;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rdc(4'h0, 8'h00);
      for (int i = 1; i < 6; i++) bus(1'b1, 4'(i), 8'(8'h10 + i));
      for (int i = 1; i < 6; i++) rdc(4'(i), 8'(8'h10 + i));
      rdAddrA <= 5'h05;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         {wrEn, wrWide, wrAddr, wrData} <= i ? {2'h3, 21'h1e1234} : {2'h2, 21'h0500a5};
         @(posedge clk);
         {wrEn, wrWide} <= 2'h0;
      end
      rf(5'h05, 1'b0, 16'ha5a5);
      ptr(2'h2, rwg_pkg::RWG_PTR_POSTINC, 6'h00, 24'h131234);
      ptr(2'h2, rwg_pkg::RWG_PTR_PREDEC, 6'h00, 24'h131234);
      ptr(2'h2, rwg_pkg::RWG_PTR_DISP, 6'h3f, 24'h131273);
      ptr(2'h1, rwg_pkg::RWG_PTR_PREDEC, 6'h00, 24'h12ffff);
      ptr(2'h0, rwg_pkg::RWG_PTR_DISP, 6'h01, 24'h110001);
      rf(5'h1e, 1'b1, 16'h1234);
      rf(5'h1d, 1'b0, 16'hffff);
      dirOperand <= 16'hbeef;
      @(posedge clk);
      @(negedge clk);
      chk("dirAddr", 24'h14beef, dirAddr);
      chk("jumpTarget", 24'h151234, jumpTarget);
      cpu.step(2'h3, rwg_pkg::RWG_FL_LOAD, 1'b0);
      @(negedge clk);
      chk("flashAddr", 24'h001234, flashAddr);
      cpu.step(2'h3, rwg_pkg::RWG_FL_EXT_LOAD, 1'b0);
      @(negedge clk);
      chk("flashAddr", 24'h131234, flashAddr);
      cpu.step(2'h3, rwg_pkg::RWG_FL_LOAD, 1'b1);
      @(negedge clk);
      chk("flashBlocked", 24'h1, {23'h0, flashBlocked});
      bus(1'b1, 4'h0, 8'h9d);
      rdc(4'h0, 8'h02);
      cpu.step(2'h3, rwg_pkg::RWG_FL_STORE, 1'b0);
      @(negedge clk);
      chk("flashBlocked", 24'h0, {23'h0, flashBlocked});
      busFromDma <= 1'b1;
      bus(1'b1, 4'h6, 8'h77);
      busFromDma <= 1'b0;
      for (int i = 0; i < 3; i++) cpu.step(2'h0, rwg_pkg::RWG_FL_STORE, 1'b0);
      rdc(4'h0, 8'h02);
      cpu.step(2'h0, rwg_pkg::RWG_FL_STORE, 1'b0);
      rdc(4'h0, 8'h00);
      for (int k = 0; k < 5; k++) begin
         busFromDma <= k == 3;
         bus(1'b1, 4'h0, sg[k]);
         busFromDma <= 1'b0;
         rdc(4'h0, gv[k]);
         chk("intSuppress", {23'h0, gv[k] != 8'h0}, {23'h0, intSuppress});
         cpu.step(ev[k], rwg_pkg::RWG_FL_LOAD, 1'b0);
         rdc(4'h0, 8'h00);
      end
      bus(1'b1, 4'h9, 8'hff);
      bus(1'b1, 4'ha, 8'h07);
      rdc(4'h9, 8'h00);
      rdc(4'ha, 8'h08);
      for (int i = 0; i < 4; i++) bus(1'b1, 4'(11 + i), 8'(8'h11 * (i + 1)));
      for (int i = 0; i < 4; i++) rdc(4'(11 + i), 8'(8'h11 * (i + 1)));
      bus(1'b1, 4'h7, 8'h5a);
      rdc(4'h7, 8'h5a);
      rdc(4'hf, 8'h00);
      byteenable <= 4'h0;
      bus(1'b1, 4'h1, 8'h99);
      byteenable <= 4'h1;
      rdc(4'h1, 8'h11);
      wrap_up();
   end
endmodule
`default_nettype wire
